// *** pin_request.sv ***
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module pin_request (
	input  wire logic                               clk,
	input  wire logic                               resetn,
	input  wire logic                               irq_pin,
	input  wire logic [pin_request_pkg::ADDR_W-1:0] addr,
	input  wire logic [pin_request_pkg::DATA_W-1:0] wdata,
	input  wire logic                               wr,
	input  wire logic                               rd,
	output logic      [pin_request_pkg::DATA_W-1:0] rdata,
	output logic                                    pull_enable,
	output logic                                    pull_select_down,
	output logic                                    pin_request_irq,
	output logic                                    event_irq
);

	// Control bits of the status and control register
	logic                              pull_device_disable;
	logic                              active_polarity_select;
	logic                              pin_function_enable;
	logic                              request_interrupt_enable;
	logic                              detection_mode_select;

	// Flag state and its next value
	pin_request_pkg::flag_state_e      flag_state;
	pin_request_pkg::flag_state_e      next_flag_state;
	logic                              request_event_flag;

	// Sticky event status and its mask
	logic [pin_request_pkg::EVT_W-1:0] evt_status;
	logic [pin_request_pkg::EVT_W-1:0] evt_mask;
	logic [pin_request_pkg::EVT_W-1:0] evt_set;
	logic [pin_request_pkg::EVT_W-1:0] evt_clear;

	// Pin path
	logic                              pin_synced;
	logic                              edge_seen;
	logic                              level_active;

	// Bus decode
	logic                              wr_ctrl;
	logic                              wr_mask;
	logic                              rd_status;
	logic                              request_acknowledge;

	// Detection qualifiers
	logic                              set_request;
	logic                              hold_request;
	logic                              ack_refused;
	logic                              flag_raised;

	detect_if                          det ();

	// Asynchronous pin passes two stages before any logic sees it
	pin_sync #(
		.RST (pin_request_pkg::RST_PIN_IDLE)
	) u_pin_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      (irq_pin),
		.q      (pin_synced)
	);

	// Feed the detector with the sample and the chosen sense
	assign det.sample   = pin_synced;
	assign det.polarity = active_polarity_select;
	assign edge_seen    = det.edge_seen;
	assign level_active = det.level_active;

	sense_detect u_sense_detect (
		.clk    (clk),
		.resetn (resetn),
		.det    (det)
	);

	// Address decode of the plain register port
	assign wr_ctrl   = wr && (addr == pin_request_pkg::OFF_STATUS_CONTROL);
	assign wr_mask   = wr && (addr == pin_request_pkg::OFF_EVENT_MASK);
	assign rd_status = rd && (addr == pin_request_pkg::OFF_EVENT_STATUS);

	// Acknowledge acts only on a written 1
	assign request_acknowledge = wr_ctrl &&
		wdata[pin_request_pkg::BIT_ACK];

	// A qualifying event only counts while the pin function is on
	assign set_request = pin_function_enable &&
		(edge_seen ||
		(detection_mode_select && level_active));

	// Active level in level mode blocks any acknowledge
	assign hold_request = pin_function_enable &&
		detection_mode_select && level_active;

	assign request_event_flag =
		(flag_state != pin_request_pkg::FLAG_IDLE);

	// Flag events for the sticky status register
	assign flag_raised = (flag_state == pin_request_pkg::FLAG_IDLE) &&
		set_request;
	assign ack_refused = request_acknowledge && request_event_flag &&
		(hold_request || set_request);

	// Control bits; flag and acknowledge positions are not stored
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pull_device_disable      <= pin_request_pkg::RST_CTRL_BIT;
			active_polarity_select   <= pin_request_pkg::RST_CTRL_BIT;
			pin_function_enable      <= pin_request_pkg::RST_CTRL_BIT;
			request_interrupt_enable <= pin_request_pkg::RST_CTRL_BIT;
			detection_mode_select    <= pin_request_pkg::RST_CTRL_BIT;
		end else if (wr_ctrl) begin
			pull_device_disable      <= wdata[pin_request_pkg::BIT_PDD];
			active_polarity_select   <= wdata[pin_request_pkg::BIT_EDG];
			pin_function_enable      <= wdata[pin_request_pkg::BIT_PE];
			request_interrupt_enable <= wdata[pin_request_pkg::BIT_IE];
			detection_mode_select    <= wdata[pin_request_pkg::BIT_MODE];
		end
	end

	// Next flag state; a set in the acknowledge cycle wins
	always_comb begin
		next_flag_state = flag_state;
		unique case (flag_state)
			pin_request_pkg::FLAG_IDLE: begin
				if (hold_request) begin
					next_flag_state = pin_request_pkg::FLAG_HELD;
				end else if (set_request) begin
					next_flag_state = pin_request_pkg::FLAG_PENDING;
				end
			end
			pin_request_pkg::FLAG_PENDING: begin
				if (hold_request) begin
					next_flag_state = pin_request_pkg::FLAG_HELD;
				end else if (request_acknowledge && !set_request) begin
					next_flag_state = pin_request_pkg::FLAG_IDLE;
				end
			end
			pin_request_pkg::FLAG_HELD: begin
				// Acknowledge ignored here; release only drops to pending
				if (!hold_request) begin
					next_flag_state = pin_request_pkg::FLAG_PENDING;
				end
			end
			default: begin
				next_flag_state = pin_request_pkg::FLAG_IDLE;
			end
		endcase
	end

	// Flag state register, written by hardware only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flag_state <= pin_request_pkg::FLAG_IDLE;
		end else begin
			flag_state <= next_flag_state;
		end
	end

	// Sticky event sources and their read-clear
	always_comb begin
		evt_set = '0;
		evt_set[pin_request_pkg::EVT_RAISED]  = flag_raised;
		evt_set[pin_request_pkg::EVT_REFUSED] = ack_refused;
		evt_clear = rd_status ? '1 : '0;
	end

	// Set beats the clearing read so no event is lost
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			evt_status <= pin_request_pkg::RST_EVT;
		end else begin
			evt_status <= (evt_status & ~evt_clear) | evt_set;
		end
	end

	// Event mask, same layout as the status
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			evt_mask <= pin_request_pkg::RST_EVT;
		end else if (wr_mask) begin
			evt_mask <= wdata[pin_request_pkg::EVT_W-1:0];
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= pin_request_pkg::RST_RDATA;
		end else if (!rd) begin
			rdata <= pin_request_pkg::RST_RDATA;
		end else begin
			rdata <= pin_request_pkg::RST_RDATA;
			case (addr)
				pin_request_pkg::OFF_STATUS_CONTROL: begin
					rdata[pin_request_pkg::BIT_PDD]  <= pull_device_disable;
					rdata[pin_request_pkg::BIT_EDG]  <= active_polarity_select;
					rdata[pin_request_pkg::BIT_PE]   <= pin_function_enable;
					rdata[pin_request_pkg::BIT_FLAG] <= request_event_flag;
					rdata[pin_request_pkg::BIT_ACK]  <= 1'b0;
					rdata[pin_request_pkg::BIT_IE]   <= request_interrupt_enable;
					rdata[pin_request_pkg::BIT_MODE] <= detection_mode_select;
				end
				pin_request_pkg::OFF_EVENT_STATUS: begin
					rdata[pin_request_pkg::EVT_W-1:0] <= evt_status;
				end
				pin_request_pkg::OFF_EVENT_MASK: begin
					rdata[pin_request_pkg::EVT_W-1:0] <= evt_mask;
				end
				pin_request_pkg::OFF_PIN_VIEW: begin
					rdata[pin_request_pkg::VIEW_SYNC]   <= pin_synced;
					rdata[pin_request_pkg::VIEW_ACTIVE] <= level_active;
				end
				default: begin
					// Unmapped offsets read as zero
					rdata <= pin_request_pkg::RST_RDATA;
				end
			endcase
		end
	end

	// Pull device control; off whenever the pin function is off
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pull_enable      <= 1'b0;
			pull_select_down <= 1'b0;
		end else begin
			pull_enable      <= pin_function_enable &&
				!pull_device_disable;
			pull_select_down <= pin_function_enable &&
				active_polarity_select;
		end
	end

	// Request line; one cycle behind the flag, cheap and glitch free
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_request_irq <= 1'b0;
		end else begin
			pin_request_irq <= request_event_flag &&
				request_interrupt_enable;
		end
	end

	// Event interrupt level from masked sticky status
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			event_irq <= 1'b0;
		end else begin
			event_irq <= |(evt_status & evt_mask);
		end
	end

endmodule // pin_request

// *** pin_request_pkg.sv ***
package pin_request_pkg;
	// Register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFF_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFF_EVENT_STATUS   = 8'h01;
	localparam logic [7:0] OFF_EVENT_MASK     = 8'h02;
	localparam logic [7:0] OFF_PIN_VIEW       = 8'h03;

	// Field positions of the status and control register
	localparam int BIT_MODE   = 0;
	localparam int BIT_IE     = 1;
	localparam int BIT_ACK    = 2;
	localparam int BIT_FLAG   = 3;
	localparam int BIT_PE     = 4;
	localparam int BIT_EDG    = 5;
	localparam int BIT_PDD    = 6;

	// Field positions of the event status and mask registers
	localparam int EVT_W        = 2;
	localparam int EVT_RAISED   = 0;
	localparam int EVT_REFUSED  = 1;

	// Field positions of the pin view register
	localparam int VIEW_SYNC    = 0;
	localparam int VIEW_ACTIVE  = 1;

	// Reset values
	localparam logic       RST_CTRL_BIT = 1'b0;
	localparam logic [1:0] RST_EVT      = 2'h0;
	localparam logic [7:0] RST_RDATA    = 8'h00;
	localparam logic       RST_PIN_IDLE = 1'b1;

	// Request flag states, Gray coded along idle, pending, held
	typedef enum logic [1:0] {
		FLAG_IDLE    = 2'h0,
		FLAG_PENDING = 2'h1,
		FLAG_HELD    = 2'h3
	} flag_state_e;
endpackage

// *** detect_if.sv ***
`timescale 1ns/1ps
// Pin sample, sense selection and detection results
interface detect_if;
	logic sample;
	logic polarity;
	logic edge_seen;
	logic level_active;

	modport detector (
		input  sample,
		input  polarity,
		output edge_seen,
		output level_active
	);

	modport owner (
		output sample,
		output polarity,
		input  edge_seen,
		input  level_active
	);
endinterface

// *** pin_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for an asynchronous level
module pin_sync #(
	parameter logic RST = 1'b1
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic d,
	output logic      q
);
	logic meta;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta <= RST;
			q    <= RST;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // pin_sync

// *** sense_detect.sv ***
`timescale 1ns/1ps
// Turns the synchronised pin into active level and active edge
module sense_detect (
	input  wire logic clk,
	input  wire logic resetn,
	detect_if.detector det
);
	logic prev_active;

	// Polarity folds both senses into one active level
	assign det.level_active = det.polarity ? det.sample : ~det.sample;
	assign det.edge_seen    = det.level_active & ~prev_active;

	// Change of polarity may look like an edge; callers accept that
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev_active <= 1'b0;
		end else begin
			prev_active <= det.level_active;
		end
	end
endmodule // sense_detect

// *** pin_driver.sv ***
`timescale 1ns/1ps
// External device: a push-pull driver that always holds the pin
module pin_driver (
	input  wire logic clk,
	input  wire logic level,
	output logic      irq_pin
);
	// Launched on the clock, so the pin never moves in a sampling step
	always_ff @(posedge clk) irq_pin <= level;
endmodule // pin_driver

// *** pin_request_asserts.sv ***
`timescale 1ns/1ps
module pin_request_asserts (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       irq_pin,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       pull_enable,
	input wire logic       pull_select_down,
	input wire logic       pin_request_irq
);
	logic [7:0] cfg;
	logic [3:0] quiet;
	logic       ctl_wr;
	assign ctl_wr = wr && addr == pin_request_pkg::OFF_STATUS_CONTROL;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// Shadow of the control bits as software last wrote them
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) cfg <= 8'h00;
		else if (ctl_wr) cfg <= wdata;
	end
	// Pin still time; edges in the synchroniser must drain first
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) quiet <= 4'h0;
		else if (!$stable(irq_pin)) quiet <= 4'h0;
		else if (quiet != 4'hf) quiet <= quiet + 4'h1;
	end

	sequence s_cfg_held;
		ctl_wr ##1 !ctl_wr;
	endsequence
	sequence s_active_edge;
		cfg[4] && cfg[1] && (cfg[5] ? $rose(irq_pin) : $fell(irq_pin))
			##0 (!wr)[*5];
	endsequence

	a_ack_reads_zero:
		assert property (rd && addr == 8'h00 |=> !rdata[2])
		else $error("ack bit read as one");
	a_pull_on_off:
		assert property (s_cfg_held |-> ##1
			pull_enable == (cfg[4] && !cfg[6]))
		else $error("pull enable wrong");
	a_pull_down_rise:
		assert property (s_cfg_held |-> ##1
			pull_select_down == (cfg[4] && cfg[5]))
		else $error("pull direction wrong");
	a_irq_needs_enable:
		assert property (!cfg[1] |=> !pin_request_irq)
		else $error("request with enable clear");
	a_irq_tracks_flag:
		assert property (rd && addr == 8'h00 |=>
			pin_request_irq == (rdata[3] && rdata[1]))
		else $error("request disagrees with flag");
	a_edge_sets_flag:
		assert property (s_active_edge |-> ##[0:1] pin_request_irq)
		else $error("edge raised no request");
	a_ack_clears_flag:
		assert property (ctl_wr && wdata[2] && !cfg[0] && quiet > 4
			&& (wdata & 8'h31) == (cfg & 8'h31) |=> ##1 !pin_request_irq)
		else $error("ack left request up");
	a_level_holds_flag:
		assert property (ctl_wr && wdata[2] && cfg[0] && cfg[1] && cfg[4]
			&& irq_pin == cfg[5] && quiet > 4
			&& (wdata & 8'h33) == (cfg & 8'h33) |=> ##1 pin_request_irq)
		else $error("ack cleared held level");
endmodule // pin_request_asserts

bind pin_request pin_request_asserts chk (.clk, .resetn, .irq_pin, .addr,
	.wdata, .wr, .rd, .rdata, .pull_enable, .pull_select_down,
	.pin_request_irq);

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
	logic       clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
	logic       level = 1'b1, irq_pin, pull_enable, pull_select_down;
	logic       pin_request_irq, event_irq;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, c, v;
	int         n_errors = 0, total_checks = 0;

	always #4 clk = ~clk;

	pin_request DUT (.clk, .resetn, .irq_pin, .addr, .wdata, .wr, .rd,
		.rdata, .pull_enable, .pull_select_down, .pin_request_irq,
		.event_irq);
	pin_driver far (.clk, .level, .irq_pin);

	// Control readback: ack and top bit read 0, flag as predicted
	function automatic logic [7:0] exp_ctrl(input logic [7:0] d,
		input logic f);
		return (d & 8'h73) | {4'h0, f, 3'h0};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data only stand in the cycle after the strobe
	task automatic get(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic pin(input logic x, input int n);
		@(posedge clk);
		level <= x;
		repeat (n) @(posedge clk);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard, far above one full run
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		conclude();
	end

	// First four passes are fixed corners, then random setups
	initial begin
		void'($urandom(91));
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		put(8'h04, 8'h7f);
		get(8'h04);
		check(v, 8'h00);
		get(8'h00);
		check(v, 8'h00);
		for (int i = 0; i < 16; i++) begin
			c = ($urandom & 8'hf3) | 8'h08;
			if (i < 4)
				c = 8'h9a | {2'h0, i[0], 4'h0, i[1]};
			put(8'h02, {7'h0, c[7]});
			get(8'h02);
			check(v, {7'h0, c[7]});
			pin(!c[5], 1);
			put(8'h00, c);
			repeat (6) @(posedge clk);
			put(8'h00, c | 8'h04);
			repeat (4) @(posedge clk);
			// Nothing may have been raised since the last clearing read
			get(8'h01);
			check(v, 8'h00);
			get(8'h00);
			check(v, exp_ctrl(c, 1'b0));
			check({6'h0, pull_select_down, pull_enable},
				{6'h0, c[4] & c[5], c[4] & !c[6]});
			pin(c[5], 6);
			// Pin view: synchronised pin and active level
			get(8'h03);
			check(v, {6'h0, 1'b1, c[5]});
			check({7'h0, event_irq}, {7'h0, c[4] & c[7]});
			get(8'h00);
			check(v, exp_ctrl(c, c[4]));
			check({7'h0, pin_request_irq}, {7'h0, c[4] & c[1]});
			put(8'h00, c);
			get(8'h00);
			check(v, exp_ctrl(c, c[4]));
			put(8'h00, c | 8'h04);
			get(8'h00);
			check(v, exp_ctrl(c, c[4] & c[0]));
			pin(!c[5], 4);
			put(8'h00, c | 8'h04);
			get(8'h00);
			check(v, exp_ctrl(c, 1'b0));
			// Raised once; refused only by the ack against a held level
			get(8'h01);
			check(v, {6'h0, c[4] & c[0], c[4]});
		end
		conclude();
	end
endmodule // tb
